// ### inc/timer_ctrl_pkg.sv
package timer_ctrl_pkg;
    // ------------------------------------------------------------
    // register map: word indices, byte address is four times each
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_CTRL_ONE = 4'ha;
    localparam logic [3:0] IDX_CTRL_TWO = 4'hb;
    localparam logic [3:0] IDX_STATUS = 4'hc;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    // ------------------------------------------------------------
    // control register one fields
    // ------------------------------------------------------------
    localparam int ONE_EDGE_FLAG = 7;
    localparam int ONE_IRQ_EN = 6;
    localparam int ONE_OUT_EN = 5;
    localparam int ONE_CLK_SEL = 1;
    localparam int ONE_MON_LOAD = 0;
    // ------------------------------------------------------------
    // control register two fields
    // ------------------------------------------------------------
    localparam int TWO_RSVD = 7;
    localparam int TWO_IRQ_EN = 6;
    localparam int TWO_T2_PRESCALE = 5;
    localparam int TWO_T2_CLK_SEL = 4;
    localparam int TWO_T2_RUN = 3;
    localparam int TWO_T1_PRESCALE = 2;
    localparam int TWO_T1_CLK_SEL = 1;
    localparam int TWO_T1_RUN = 0;
    // ------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### design/ctrl_reg_bank.sv
`timescale 1ns/10ps
// two-word store for the control bytes, registered read port
module ctrl_reg_bank #(
    parameter int WIDTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic i_wsel,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_rsel,
    output logic [WIDTH-1:0] o_rdata,
    output logic [WIDTH-1:0] o_word0,
    output logic [WIDTH-1:0] o_word1
);
    logic [WIDTH-1:0] mem_q [2];

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            o_rdata <= '0;
        end else begin
            if (i_we) begin
                mem_q[i_wsel] <= i_wdata;
            end
            o_rdata <= mem_q[i_rsel];
        end
    end

    assign o_word0 = mem_q[0];
    assign o_word1 = mem_q[1];
endmodule

// ### design/timer_control_regs.sv
`timescale 1ns/10ps
// Operation
// - set edge flag on timer a edge
// - write one clears flag, zero keeps
// - flag never set while uart runs
// - bit five enables timer a output
// - serial bit zero hands pins to uart
// - bit one selects fast processor clock
// - register two bit six enables interrupt
// - bit four: timer 2 counts slow clock
// - rising load bit reloads, activates monitor
// - prescale mode reloads low counter; none for m
module timer_control_regs (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic i_timer_a_edge,
    input wire logic i_serial_control_bit_zero,
    output logic o_timer_a_edge_flag,
    output logic o_timer_a_irq,
    output logic o_timer_a_output_enable,
    output logic o_uart_owns_pins,
    output logic o_cpu_clock_select,
    output logic o_monitor_reload,
    output logic o_monitor_active,
    output logic o_first_timer_prescale_mode,
    output logic o_first_timer_clock_select,
    output logic o_first_timer_run,
    output logic o_second_timer_prescale_mode,
    output logic o_second_timer_clock_select,
    output logic o_second_timer_run
);
    // ------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------
    logic aw_full_q;
    logic w_full_q;
    logic [3:0] aw_idx_q;
    logic [7:0] w_byte_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
    wire wr_one = wr_fire && (aw_idx_q == timer_ctrl_pkg::IDX_CTRL_ONE);
    wire wr_two = wr_fire && (aw_idx_q == timer_ctrl_pkg::IDX_CTRL_TWO);
    wire wr_hit = wr_one || wr_two ||
        (aw_idx_q == timer_ctrl_pkg::IDX_STATUS);
    wire wr_one_en = wr_one && w_lane_q;
    wire wr_two_en = wr_two && w_lane_q;
    // next-state views feed the registered ready flags
    wire aw_full_d = !wr_fire && (aw_take || aw_full_q);
    wire w_full_d = !wr_fire && (w_take || w_full_q);
    wire bvalid_d = wr_fire || (bvalid_q && !s_axi_bready);
    wire awready_d = !aw_full_d && !bvalid_d;
    wire wready_d = !w_full_d && !bvalid_d;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_idx_q <= 4'h0;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= timer_ctrl_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[5:2];
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? timer_ctrl_pkg::RESP_OKAY
                                  : timer_ctrl_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control bytes
    // ------------------------------------------------------------
    logic [7:0] one_q;
    logic [7:0] two_q;
    logic [7:0] bank_rdata;
    logic edge_flag_q;
    logic mon_bit_q;
    logic mon_active_q;
    logic mon_reload_q;

    wire [7:0] two_wr = w_byte_q & ~(8'h01 << timer_ctrl_pkg::TWO_RSVD);

    ctrl_reg_bank #(.WIDTH(8)) u_bank (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_we(wr_one_en || wr_two_en),
        .i_wsel(wr_two_en),
        .i_wdata(wr_two_en ? two_wr : w_byte_q),
        .i_rsel(s_axi_araddr[2]),
        .o_rdata(bank_rdata),
        .o_word0(one_q),
        .o_word1(two_q)
    );

    // edge flag: hardware set wins over software clear
    wire uart_on = i_serial_control_bit_zero;
    wire edge_set = i_timer_a_edge && !uart_on;
    wire edge_clr = wr_one_en && w_byte_q[timer_ctrl_pkg::ONE_EDGE_FLAG];
    wire edge_d = edge_set || (edge_flag_q && !edge_clr);

    // monitor load sees only rising transitions of the stored bit
    wire mon_new = wr_one_en ? w_byte_q[timer_ctrl_pkg::ONE_MON_LOAD]
                             : mon_bit_q;
    wire mon_rise = mon_new && !mon_bit_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            edge_flag_q <= 1'b0;
            mon_bit_q <= 1'b0;
            mon_active_q <= 1'b0;
            mon_reload_q <= 1'b0;
        end else begin
            edge_flag_q <= edge_d;
            mon_bit_q <= mon_new;
            mon_reload_q <= mon_rise;
            if (mon_rise) begin
                mon_active_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic rd_pend_q;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic rsel_one_q;
    logic rsel_two_q;
    logic rsel_stat_q;
    logic [1:0] rresp_q;

    wire [3:0] ar_idx = s_axi_araddr[5:2];
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rvalid_d = rd_pend_q || (rvalid_q && !s_axi_rready);
    wire arready_d = !ar_take && !rvalid_d;
    wire ar_one = ar_idx == timer_ctrl_pkg::IDX_CTRL_ONE;
    wire ar_two = ar_idx == timer_ctrl_pkg::IDX_CTRL_TWO;
    wire ar_stat = ar_idx == timer_ctrl_pkg::IDX_STATUS;
    wire [7:0] rd_one = {edge_flag_q, bank_rdata[6:0]};
    wire [7:0] rd_stat = {6'h00, uart_on, mon_active_q};
    wire [7:0] rd_byte = rsel_one_q ? rd_one :
                         rsel_two_q ? bank_rdata :
                         rsel_stat_q ? rd_stat : 8'h00;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rd_pend_q <= 1'b0;
            rvalid_q <= 1'b0;
            rsel_one_q <= 1'b0;
            rsel_two_q <= 1'b0;
            rsel_stat_q <= 1'b0;
            rresp_q <= timer_ctrl_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            rd_pend_q <= ar_take;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rsel_one_q <= ar_one;
                rsel_two_q <= ar_two;
                rsel_stat_q <= ar_stat;
                rresp_q <= (ar_one || ar_two || ar_stat)
                    ? timer_ctrl_pkg::RESP_OKAY
                    : timer_ctrl_pkg::RESP_SLVERR;
            end
            // bank word lags the take by a cycle, hence the extra stage
            if (rd_pend_q) begin
                rdata_q <= {24'h000000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    wire irq_en = two_q[timer_ctrl_pkg::TWO_IRQ_EN];
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            o_timer_a_irq <= 1'b0;
            o_timer_a_output_enable <= 1'b0;
            o_uart_owns_pins <= 1'b0;
            o_cpu_clock_select <= 1'b0;
            o_first_timer_prescale_mode <= 1'b0;
            o_first_timer_clock_select <= 1'b0;
            o_first_timer_run <= 1'b0;
            o_second_timer_prescale_mode <= 1'b0;
            o_second_timer_clock_select <= 1'b0;
            o_second_timer_run <= 1'b0;
        end else begin
            // ready means a free slot; it drops on the take edge
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
            s_axi_arready <= arready_d;
            o_timer_a_irq <= edge_d && irq_en;
            o_timer_a_output_enable <= one_q[timer_ctrl_pkg::ONE_OUT_EN]
                && !uart_on;
            o_uart_owns_pins <= uart_on;
            o_cpu_clock_select <= one_q[timer_ctrl_pkg::ONE_CLK_SEL];
            o_second_timer_prescale_mode <=
                two_q[timer_ctrl_pkg::TWO_T2_PRESCALE];
            o_first_timer_prescale_mode <=
                two_q[timer_ctrl_pkg::TWO_T1_PRESCALE];
            o_second_timer_clock_select <=
                two_q[timer_ctrl_pkg::TWO_T2_CLK_SEL];
            o_second_timer_run <= two_q[timer_ctrl_pkg::TWO_T2_RUN];
            o_first_timer_run <= two_q[timer_ctrl_pkg::TWO_T1_RUN];
            o_first_timer_clock_select <=
                two_q[timer_ctrl_pkg::TWO_T1_CLK_SEL];
        end
    end

    // bus answers and flags come straight from their flops
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign o_timer_a_edge_flag = edge_flag_q;
    assign o_monitor_active = mon_active_q;
    assign o_monitor_reload = mon_reload_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    flag_sets_a: assert property (
        i_timer_a_edge && !uart_on |=> edge_flag_q)
        else $error("edge flag not set");
    flag_clear_a: assert property (
        edge_clr && !edge_set |=> !edge_flag_q)
        else $error("flag not cleared");
    flag_hold_a: assert property (
        edge_flag_q && !edge_clr |=> edge_flag_q)
        else $error("flag lost");
    uart_block_a: assert property (
        !edge_flag_q && uart_on |=> !edge_flag_q)
        else $error("flag set in uart use");
    out_gate_a: assert property (
        uart_on |=> !o_timer_a_output_enable)
        else $error("output on in uart use");
    uart_pins_a: assert property (
        uart_on |=> o_uart_owns_pins)
        else $error("pins not handed to uart");
    irq_gate_a: assert property (
        !irq_en && !$past(irq_en) |-> !o_timer_a_irq)
        else $error("irq while off");
    t2_mode_a: assert property (
        wr_two_en ##1 1 |=> o_second_timer_prescale_mode
        == $past(w_byte_q[timer_ctrl_pkg::TWO_T2_PRESCALE], 2))
        else $error("timer 2 mode stale");
    t2_clk_a: assert property (
        wr_two_en ##1 1 |=> o_second_timer_clock_select
        == $past(w_byte_q[timer_ctrl_pkg::TWO_T2_CLK_SEL], 2))
        else $error("timer 2 clock stale");
    run_follow_a: assert property (
        wr_two_en ##1 1 |=> o_first_timer_run == $past(w_byte_q[0], 2))
        else $error("run bit stale");
    mon_once_a: assert property (
        o_monitor_reload |-> o_monitor_active)
        else $error("reload without activate");
    mon_fall_a: assert property (
        mon_bit_q && !mon_new |=> !o_monitor_reload)
        else $error("reload on falling");
    clk_sel_a: assert property (
        wr_one_en ##1 1 |=> o_cpu_clock_select == $past(w_byte_q[1], 2))
        else $error("clock sel stale");

    wr_seen_c: cover property (wr_fire ##[1:4] s_axi_bvalid);
    rd_seen_c: cover property (ar_take ##1 s_axi_rvalid);
    race_c: cover property (edge_set && edge_clr);
    mon_c: cover property (mon_rise);
endmodule

// ### bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------------------
    // clock, reset, bus signals
    // ------------------------------------------------------------
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, edge_in = 1'b0, uart = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rd;
    logic flag, irq, oen, owns, csel, reload, act;
    logic p1, c1, r1, p2, c2, r2;
    logic [11:0] outs;
    int fail_count = 0;
    int n_checks = 0;
    int n_reload = 0;
    logic [7:0] e1 = 8'h00, e2 = 8'h00;
    logic eflag = 1'b0, eact = 1'b0;

    always #25 i_core_clk = ~i_core_clk;
    assign outs = {flag, irq, oen, owns, csel, act, p1, c1, r1, p2, c2, r2};
    // reload is a one-cycle pulse, so it is counted, not sampled later
    always @(posedge i_core_clk) if (reload === 1'b1) n_reload++;

    timer_control_regs u_timer_control_regs (
        .i_core_clk(i_core_clk), .i_rst(i_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .i_timer_a_edge(edge_in),
        .i_serial_control_bit_zero(uart), .o_timer_a_edge_flag(flag),
        .o_timer_a_irq(irq), .o_timer_a_output_enable(oen),
        .o_uart_owns_pins(owns), .o_cpu_clock_select(csel),
        .o_monitor_reload(reload), .o_monitor_active(act),
        .o_first_timer_prescale_mode(p1),
        .o_first_timer_clock_select(c1), .o_first_timer_run(r1),
        .o_second_timer_prescale_mode(p2),
        .o_second_timer_clock_select(c2), .o_second_timer_run(r2)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic timed_out();
        fail_count++;
        $display("mismatch t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        finish_test();
    endtask

    // outputs settle one cycle after the response, so allow three
    task automatic chk_outs();
        repeat (3) @(posedge i_core_clk);
        cmp({20'h0, outs}, {20'h0, eflag, eflag & e2[6], e1[5] & ~uart,
            uart, e1[1], eact, e2[2], e2[1], e2[0], e2[5], e2[4], e2[3]});
    endtask

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        logic aw_done, w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge i_core_clk);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge i_core_clk);
            if (++n > 100) timed_out();
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) begin
            @(posedge i_core_clk);
            if (++n > 100) timed_out();
        end
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [31:0] a);
        int n;
        n = 0;
        @(posedge i_core_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (++n > 100) timed_out();
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) begin
            @(posedge i_core_clk);
            if (++n > 100) timed_out();
        end
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic pulse_edge();
        @(posedge i_core_clk);
        edge_in <= 1'b1;
        @(posedge i_core_clk);
        edge_in <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        rd_reg(32'h28); cmp(rd, 32'h0);
        rd_reg(32'h2c); cmp(rd, 32'h0);
        chk_outs();
        $display("test reset done");
        // walk each bit of register two, bit 7 must read back zero
        for (int i = 0; i < 8; i++) begin
            e2 = 8'h01 << i;
            wr(32'h2c, {24'h0, e2}, 4'hf);
            cmp({30'h0, resp}, 32'h0);
            e2[7] = 1'b0;
            rd_reg(32'h2c); cmp(rd, {24'h0, e2});
            chk_outs();
        end
        e1 = 8'h62;
        wr(32'h28, {24'h0, e1}, 4'hf);
        rd_reg(32'h28); cmp(rd, {24'h0, e1});
        chk_outs();
        uart <= 1'b1;
        pulse_edge();
        chk_outs();
        uart <= 1'b0;
        $display("test control bits done");
        e2 = 8'h40;
        wr(32'h2c, {24'h0, e2}, 4'hf);
        pulse_edge();
        eflag = 1'b1;
        chk_outs();
        rd_reg(32'h28); cmp(rd, {24'h0, 8'h80 | e1});
        wr(32'h28, {24'h0, e1}, 4'hf);
        chk_outs();
        wr(32'h28, {24'h0, 8'h80 | e1}, 4'hf);
        eflag = 1'b0;
        chk_outs();
        $display("test edge flag done");
        e1 = 8'h01;
        wr(32'h28, 32'h01, 4'hf);
        eact = 1'b1;
        chk_outs();
        cmp(n_reload, 32'h1);
        wr(32'h28, 32'h00, 4'hf);
        e1 = 8'h00;
        chk_outs();
        cmp(n_reload, 32'h1);
        wr(32'h28, 32'h01, 4'hf);
        chk_outs();
        cmp(n_reload, 32'h2);
        rd_reg(32'h30); cmp({31'h0, rd[0]}, 32'h1);
        $display("test monitor done");
        wr(32'h40, 32'hff, 4'hf);
        cmp({30'h0, resp}, {30'h0, timer_ctrl_pkg::RESP_SLVERR});
        rd_reg(32'h40);
        cmp({30'h0, resp}, {30'h0, timer_ctrl_pkg::RESP_SLVERR});
        wr(32'h2c, 32'h3f, 4'h0);
        rd_reg(32'h2c); cmp(rd, {24'h0, e2});
        $display("test refusals done");
        // a second reset must drop the sticky monitor state
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(posedge i_core_clk);
        e1 = 8'h00;
        e2 = 8'h00;
        eact = 1'b0;
        chk_outs();
        rd_reg(32'h2c); cmp(rd, 32'h0);
        $display("test second reset done");
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge i_core_clk);
        timed_out();
    end
endmodule
